// ===== design/eei_pkg.sv
/*
 * Shared constants, state encoding and carrier types for the two-wire
 * memory target interface.
 * Assumes a 100 MHz system clock and a 4096 x 8 array, 32-byte pages.
 */
`default_nettype none

package eei_pkg;

    // ****************************************************************
    // array geometry
    // ****************************************************************
    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned PAGE_W     = 5;
    localparam int unsigned PAGES      = 128;
    localparam int unsigned PAGE_BYTES = 32;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned ARR_DEPTH  = PAGES * PAGE_BYTES;

    // ****************************************************************
    // protocol constants
    // ****************************************************************
    localparam logic [3:0] DEV_TYPE     = 4'hA;
    localparam logic [3:0] BYTE_BITS    = 4'h8;
    localparam logic [5:0] PAGE_LAST    = 6'h20;
    localparam logic       LINE_IDLE    = 1'b1;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLK_MHZ      = 100;
    localparam int unsigned PROG_TIME_US = 5000;
    localparam int unsigned PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
    localparam int unsigned FILT_CYCLES  = 3;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEV  = 3'h1,
        ST_AHI  = 3'h2,
        ST_ALO  = 3'h3,
        ST_WR   = 3'h4,
        ST_RD   = 3'h5
    } eei_state_e;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic bit_val;
    } eei_evt_s;

endpackage : eei_pkg

`default_nettype wire

// ===== design/eei_mem.sv
/*
 * Simple one-write, one-read memory with registered read data.
 * Assumes a single clock; read data appear one enabled edge after raddr.
 */
`default_nettype none

module eei_mem #(
    parameter int unsigned DW    = 8,
    parameter int unsigned DEPTH = 32,
    parameter int unsigned AW    = 5
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem_q [DEPTH];
    logic [DW-1:0] rdata_ff;

    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem_q[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= '0;
        end else if (ce) begin
            rdata_ff <= mem_q[raddr];
        end
    end

    assign rdata = rdata_ff;

endmodule : eei_mem

`default_nettype wire

// ===== design/eei_filt.sv
/*
 * Pin synchroniser followed by a stability filter.
 * Assumes an asynchronous pin; output moves only after FILT stable samples.
 */
`default_nettype none

module eei_filt #(
    parameter int unsigned FILT = 3,
    parameter logic        INIT = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic pin,
    output logic      level
);

    localparam int unsigned CW = $clog2(FILT + 1);

    logic          s1_ff;
    logic          s2_ff;
    logic          level_ff;
    logic [CW-1:0] cnt_ff;
    logic          differ;
    logic          settled;

    assign differ  = s2_ff != level_ff;
    assign settled = cnt_ff == CW'(FILT - 1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff    <= INIT;
            s2_ff    <= INIT;
            level_ff <= INIT;
            cnt_ff   <= '0;
        end else if (ce) begin
            s1_ff <= pin;
            s2_ff <= s1_ff;
            if (differ && settled) begin
                level_ff <= s2_ff;
                cnt_ff   <= '0;
            end else if (differ) begin
                cnt_ff <= cnt_ff + CW'(1);
            end else begin
                cnt_ff <= '0;
            end
        end
    end

    assign level = level_ff;

endmodule : eei_filt

`default_nettype wire

// ===== design/eei_top.sv
/*
 * Two-wire target interface of a 4096 x 8 nonvolatile memory, memory side.
 * Assumes scl and sda come from an external controller, sda is wired-AND
 * with an external pull-up, and the pads pull straps and guard low.
 */
`default_nettype none

module eei_top #(
    parameter int unsigned PROG_CYCLES = eei_pkg::PROG_CYCLES,
    parameter int unsigned FILT_CYCLES = eei_pkg::FILT_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       scl,
    input  wire logic       sda_i,
    input  wire logic [2:0] chip_select_straps,
    input  wire logic       write_guard,
    output logic            sda_o,
    output logic            sda_oe,
    output logic            standby,
    output logic            prog_busy
);

    localparam int unsigned TW = $clog2(PROG_CYCLES + 1);
    localparam int unsigned AW = eei_pkg::ADDR_W;
    localparam int unsigned PW = eei_pkg::PAGE_W;
    localparam int unsigned DW = eei_pkg::DATA_W;

    // ****************************************************************
    // link clock domain: bit capture
    // ****************************************************************
    logic link_tog_ff;
    logic link_bit_ff;

    always_ff @(posedge scl or negedge rst_n) begin
        if (!rst_n) begin
            link_tog_ff <= 1'b0;
            link_bit_ff <= 1'b0;
        end else begin
            link_tog_ff <= ~link_tog_ff;
            link_bit_ff <= sda_i;
        end
    end

    // ****************************************************************
    // crossing and pin conditioning
    // ****************************************************************
    logic       tog_s1_ff;
    logic       tog_s2_ff;
    logic       tog_s3_ff;
    logic [3:0] pin_s1_ff;
    logic [3:0] pin_s2_ff;
    logic       scl_f;
    logic       sda_f;
    logic       scl_p_ff;
    logic       sda_p_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_s1_ff <= 1'b0;
            tog_s2_ff <= 1'b0;
            tog_s3_ff <= 1'b0;
            pin_s1_ff <= 4'h0;
            pin_s2_ff <= 4'h0;
            scl_p_ff  <= eei_pkg::LINE_IDLE;
            sda_p_ff  <= eei_pkg::LINE_IDLE;
        end else if (ce) begin
            tog_s1_ff <= link_tog_ff;
            tog_s2_ff <= tog_s1_ff;
            tog_s3_ff <= tog_s2_ff;
            pin_s1_ff <= {write_guard, chip_select_straps};
            pin_s2_ff <= pin_s1_ff;
            scl_p_ff  <= scl_f;
            sda_p_ff  <= sda_f;
        end
    end

    eei_filt #(
        .FILT (FILT_CYCLES),
        .INIT (eei_pkg::LINE_IDLE)
    ) u_scl_filt (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .pin   (scl),
        .level (scl_f)
    );

    eei_filt #(
        .FILT (FILT_CYCLES),
        .INIT (eei_pkg::LINE_IDLE)
    ) u_sda_filt (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .pin   (sda_i),
        .level (sda_f)
    );

    wire logic [2:0] straps = pin_s2_ff[2:0];
    wire logic       guard  = pin_s2_ff[3];

    eei_pkg::eei_evt_s ev;

    assign ev.start   = scl_f & scl_p_ff & sda_p_ff & ~sda_f;
    assign ev.stop    = scl_f & scl_p_ff & ~sda_p_ff & sda_f;
    assign ev.fall    = scl_p_ff & ~scl_f;
    // bit held stable for a full serial period after the toggle
    assign ev.rise    = tog_s2_ff ^ tog_s3_ff;
    assign ev.bit_val = link_bit_ff;

    // ****************************************************************
    // state
    // ****************************************************************
    eei_pkg::eei_state_e state_ff;
    eei_pkg::eei_state_e nxt_state;
    logic [3:0]          bit_cnt_ff;
    logic [3:0]          nxt_bit_cnt;
    logic                acking_ff;
    logic                nxt_acking;
    logic [7:0]          sh_ff;
    logic [7:0]          nxt_sh;
    logic [7:0]          tx_ff;
    logic [7:0]          nxt_tx;
    logic [AW-1:0]       addr_ff;
    logic [AW-1:0]       nxt_addr;
    logic [3:0]          ahi_ff;
    logic [3:0]          nxt_ahi;
    logic [31:0]         mask_ff;
    logic [31:0]         nxt_mask;
    logic [6:0]          page_ff;
    logic [6:0]          nxt_page;
    logic                sda_oe_ff;
    logic                nxt_sda_oe;
    logic                sda_o_ff;
    logic                standby_ff;
    logic                buf_we;

    logic                busy_ff;
    logic [TW-1:0]       timer_ff;
    logic [5:0]          cidx_ff;
    logic                cvalid_ff;
    logic [PW-1:0]       cidx_d_ff;
    logic [31:0]         prog_mask_ff;
    logic [6:0]          prog_page_ff;

    logic [DW-1:0]       rd_data;
    logic [DW-1:0]       buf_rdata;

    // ****************************************************************
    // decode
    // ****************************************************************
    // type code check
    wire logic type_ok  = sh_ff[7:4] == eei_pkg::DEV_TYPE;
    wire logic strap_ok = sh_ff[3:1] == straps;
    wire logic dev_ack  = type_ok & strap_ok & ~busy_ff;
    wire logic rd_sel   = sh_ff[0];
    wire logic byte_in  = bit_cnt_ff == eei_pkg::BYTE_BITS;
    wire logic rx_state = (state_ff == eei_pkg::ST_DEV) | (state_ff == eei_pkg::ST_AHI)
                        | (state_ff == eei_pkg::ST_ALO) | (state_ff == eei_pkg::ST_WR);
    // low five bits wrap within page
    wire logic [PW-1:0] low_inc = addr_ff[PW-1:0] + PW'(1);
    wire logic launch   = ev.stop & (|mask_ff) & ~busy_ff & ~guard;
    wire logic prog_end = busy_ff & (timer_ff == TW'(PROG_CYCLES - 1));
    wire logic arr_we   = cvalid_ff & prog_mask_ff[cidx_d_ff];

    // ****************************************************************
    // protocol engine
    // ****************************************************************
    always_comb begin
        nxt_state   = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_acking  = acking_ff;
        nxt_sh      = sh_ff;
        nxt_tx      = tx_ff;
        nxt_addr    = addr_ff;
        nxt_ahi     = ahi_ff;
        nxt_mask    = mask_ff;
        nxt_page    = page_ff;
        nxt_sda_oe  = sda_oe_ff;
        buf_we      = 1'b0;
        if (ev.start) begin
            nxt_state   = eei_pkg::ST_DEV;
            nxt_bit_cnt = 4'h0;
            nxt_acking  = 1'b0;
            nxt_sda_oe  = 1'b0;
            nxt_mask    = 32'h0000_0000;
        end else if (ev.stop) begin
            nxt_state  = eei_pkg::ST_IDLE;
            nxt_acking = 1'b0;
            nxt_sda_oe = 1'b0;
            nxt_mask   = 32'h0000_0000;
        end else if (rx_state && ev.rise && !acking_ff && !byte_in) begin
            nxt_sh      = {sh_ff[6:0], ev.bit_val};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
        end else if (rx_state && ev.fall && !acking_ff && byte_in) begin
            nxt_acking = 1'b1;
            nxt_sda_oe = 1'b1;
            unique case (state_ff)
                eei_pkg::ST_DEV: begin
                    if (!dev_ack) begin
                        nxt_state  = eei_pkg::ST_IDLE;
                        nxt_acking = 1'b0;
                        nxt_sda_oe = 1'b0;
                    end
                end
                eei_pkg::ST_AHI: begin
                    nxt_ahi = sh_ff[3:0];
                end
                eei_pkg::ST_ALO: begin
                    nxt_addr = {ahi_ff, sh_ff};
                end
                eei_pkg::ST_WR: begin
                    buf_we                     = 1'b1;
                    nxt_mask[addr_ff[PW-1:0]] = 1'b1;
                    nxt_page                   = addr_ff[AW-1:PW];
                    nxt_addr                   = {addr_ff[AW-1:PW], low_inc};
                end
                default: begin
                    nxt_acking = 1'b0;
                    nxt_sda_oe = 1'b0;
                end
            endcase
        end else if (rx_state && ev.fall && acking_ff) begin
            nxt_acking  = 1'b0;
            nxt_sda_oe  = 1'b0;
            nxt_bit_cnt = 4'h0;
            unique case (state_ff)
                eei_pkg::ST_DEV: begin
                    if (rd_sel) begin
                        nxt_state  = eei_pkg::ST_RD;
                        nxt_tx     = rd_data;
                        nxt_sda_oe = ~rd_data[7];
                    end else begin
                        nxt_state = eei_pkg::ST_AHI;
                    end
                end
                eei_pkg::ST_AHI: nxt_state = eei_pkg::ST_ALO;
                default:         nxt_state = eei_pkg::ST_WR;
            endcase
        end else if (state_ff == eei_pkg::ST_RD) begin
            if (ev.rise && !acking_ff) begin
                nxt_bit_cnt = bit_cnt_ff + 4'h1;
                if (bit_cnt_ff == 4'h7) begin
                    nxt_addr = addr_ff + AW'(1);
                end
            end else if (ev.fall && !acking_ff && !byte_in) begin
                nxt_tx     = {tx_ff[6:0], 1'b0};
                nxt_sda_oe = ~tx_ff[6];
            end else if (ev.fall && !acking_ff) begin
                nxt_sda_oe = 1'b0;
                nxt_acking = 1'b1;
            end else if (ev.rise && ev.bit_val) begin
                // controller did not acknowledge
                nxt_state  = eei_pkg::ST_IDLE;
                nxt_acking = 1'b0;
            end else if (ev.fall && acking_ff) begin
                nxt_acking  = 1'b0;
                nxt_bit_cnt = 4'h0;
                nxt_tx      = rd_data;
                nxt_sda_oe  = ~rd_data[7];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff   <= eei_pkg::ST_IDLE;
            bit_cnt_ff <= 4'h0;
            acking_ff  <= 1'b0;
            sh_ff      <= 8'h00;
            tx_ff      <= 8'h00;
            addr_ff    <= '0;
            ahi_ff     <= 4'h0;
            mask_ff    <= 32'h0000_0000;
            page_ff    <= 7'h00;
            sda_oe_ff  <= 1'b0;
        end else if (ce) begin
            state_ff   <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            acking_ff  <= nxt_acking;
            sh_ff      <= nxt_sh;
            tx_ff      <= nxt_tx;
            addr_ff    <= nxt_addr;
            ahi_ff     <= nxt_ahi;
            mask_ff    <= nxt_mask;
            page_ff    <= nxt_page;
            sda_oe_ff  <= nxt_sda_oe;
        end
    end

    // ****************************************************************
    // self-timed programming
    // ****************************************************************
    // fixed window then release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_ff      <= 1'b0;
            timer_ff     <= '0;
            cidx_ff      <= 6'h00;
            cvalid_ff    <= 1'b0;
            cidx_d_ff    <= '0;
            prog_mask_ff <= 32'h0000_0000;
            prog_page_ff <= 7'h00;
        end else if (ce) begin
            cvalid_ff <= busy_ff & (cidx_ff != eei_pkg::PAGE_LAST);
            cidx_d_ff <= cidx_ff[PW-1:0];
            if (launch) begin
                busy_ff      <= 1'b1;
                timer_ff     <= '0;
                cidx_ff      <= 6'h00;
                prog_mask_ff <= mask_ff;
                prog_page_ff <= page_ff;
            end else if (prog_end) begin
                busy_ff <= 1'b0;
            end else if (busy_ff) begin
                timer_ff <= timer_ff + TW'(1);
                if (cidx_ff != eei_pkg::PAGE_LAST) begin
                    cidx_ff <= cidx_ff + 6'h01;
                end
            end
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            standby_ff <= 1'b1;
            sda_o_ff   <= 1'b0;
        end else if (ce) begin
            // standby when idle and not programming
            standby_ff <= (nxt_state == eei_pkg::ST_IDLE) & ~launch & ~(busy_ff & ~prog_end);
            sda_o_ff   <= 1'b0;
        end
    end

    assign sda_o     = sda_o_ff;
    assign sda_oe    = sda_oe_ff;
    assign standby   = standby_ff;
    assign prog_busy = busy_ff;

    // ****************************************************************
    // storage
    // ****************************************************************
    eei_mem #(
        .DW    (DW),
        .DEPTH (eei_pkg::PAGE_BYTES),
        .AW    (PW)
    ) u_page_buf (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .we    (buf_we),
        .waddr (addr_ff[PW-1:0]),
        .wdata (sh_ff),
        .raddr (cidx_ff[PW-1:0]),
        .rdata (buf_rdata)
    );

    eei_mem #(
        .DW    (DW),
        .DEPTH (eei_pkg::ARR_DEPTH),
        .AW    (AW)
    ) u_array (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .we    (arr_we),
        .waddr ({prog_page_ff, cidx_d_ff}),
        .wdata (buf_rdata),
        .raddr (addr_ff),
        .rdata (rd_data)
    );

endmodule : eei_top

`default_nettype wire

// ===== sim/eei_assertions.sv
/* checker on the memory target ports
   assumes it is bound into eei_top */
`default_nettype none
module eei_assertions #(
    parameter int unsigned PROG_CYCLES = 200,
    parameter int unsigned FILT_CYCLES = 3
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       ce,
    input wire logic       scl,
    input wire logic       sda_i,
    input wire logic [2:0] chip_select_straps,
    input wire logic       write_guard,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic       standby,
    input wire logic       prog_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        sda_ff;
    logic [5:0]  stop_age_ff;
    logic [31:0] busy_cnt_ff;
    wire         stop_raw = scl && sda_i && !sda_ff;
    // ****************
    // stop age and busy length
    // ****************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_ff      <= 1'b1;
            stop_age_ff <= 6'h3F;
            busy_cnt_ff <= 32'h0;
        end else begin
            sda_ff      <= sda_i;
            stop_age_ff <= stop_raw ? 6'h0 : stop_age_ff + 6'(stop_age_ff != 6'h3F);
            busy_cnt_ff <= prog_busy ? busy_cnt_ff + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    oe_polarity_a: assert property (sda_oe |-> !sda_o)
        else $error("data line driven high");
    oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl)
        else $error("data output moved while clock high");
    busy_not_idle_a: assert property (prog_busy |-> !standby)
        else $error("standby during programming");
    busy_end_idle_a: assert property ($fell(prog_busy) |-> ##[0:1] standby)
        else $error("no standby after programming");
    busy_no_ack_a: assert property (prog_busy |-> !sda_oe)
        else $error("acknowledge while programming");
    busy_after_stop_a: assert property ($rose(prog_busy) |-> stop_age_ff < 6'h28)
        else $error("programming without stop");
    busy_guard_a: assert property ($rose(prog_busy) |-> !write_guard)
        else $error("programming while guarded");
    busy_max_a: assert property (busy_cnt_ff <= PROG_CYCLES + 2)
        else $error("programming too long");
    busy_full_a: assert property ($fell(prog_busy) |-> busy_cnt_ff + 2 >= PROG_CYCLES)
        else $error("programming cut short");
    busy_seen_c: cover property ($rose(prog_busy));
    ack_seen_c: cover property ($rose(sda_oe));
    guard_ack_c: cover property (write_guard && $rose(sda_oe));
endmodule : eei_assertions
bind eei_top eei_assertions #(.PROG_CYCLES(PROG_CYCLES), .FILT_CYCLES(FILT_CYCLES)) u_chk (
    .clk(clk), .rst_n(rst_n), .ce(ce), .scl(scl), .sda_i(sda_i), .chip_select_straps(chip_select_straps),
    .write_guard(write_guard), .sda_o(sda_o), .sda_oe(sda_oe), .standby(standby), .prog_busy(prog_busy));
`default_nettype wire

// ===== sim/eei_bus_ctrl.sv
/* two-wire bus controller model, makes the serial clock
   assumes the bench resolves the data line with a pull-up */
`default_nettype none
module eei_bus_ctrl (
    input  wire logic lclk,
    input  wire logic sda,
    output logic      scl,
    output logic      pull
);
    timeunit 1ns;
    timeprecision 1ps;
    // 13 link ticks keep each phase above 400 ns
    localparam int HALF = 13;
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    task automatic ph();
        repeat (HALF) @(posedge lclk);
    endtask : ph
    task automatic start();
        ph();
        pull <= 1'b0;
        ph();
        scl <= 1'b1;
        ph();
        pull <= 1'b1;
        ph();
        scl <= 1'b0;
    endtask : start
    task automatic stop();
        ph();
        pull <= 1'b1;
        ph();
        scl <= 1'b1;
        ph();
        pull <= 1'b0;
    endtask : stop
    task automatic put_bit(input logic b, output logic r);
        pull <= ~b;
        ph();
        scl <= 1'b1;
        ph();
        r = sda;
        scl <= 1'b0;
    endtask : put_bit
    task automatic xfer(input logic [7:0] tx, input logic ain, output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(tx[i], r);
            rx = {rx[6:0], r};
        end
        put_bit(ain, ack);
    endtask : xfer
    task automatic soft_reset();
        logic r;
        start();
        repeat (18) put_bit(1'b1, r);
    endtask : soft_reset
endmodule : eei_bus_ctrl
`default_nettype wire

// ===== sim/eei_tb_top.sv
/* self-checking bench of the memory target interface
   assumes the controller model and the bound checker */
`default_nettype none
module eei_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PROG = 1500;
    logic        clk = 1'b0;
    logic        lclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        guard = 1'b0;
    logic [2:0]  straps = 3'h0;
    logic        scl;
    logic        pull;
    logic        sda_o;
    logic        sda_oe;
    logic        standby;
    logic        busy;
    logic [31:0] rs = 32'h45;
    logic [7:0]  mem [4096];
    int          n_fail = 0;
    int          checks_done = 0;
    wire         sda = !((sda_oe && !sda_o) || pull);
    always #5 clk = ~clk;
    always #16 lclk = ~lclk;
    eei_top #(.PROG_CYCLES(PROG), .FILT_CYCLES(3)) dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .scl(scl),
        .sda_i(sda), .chip_select_straps(straps), .write_guard(guard), .sda_o(sda_o), .sda_oe(sda_oe),
        .standby(standby), .prog_busy(busy));
    eei_bus_ctrl m (.lclk(lclk), .sda(sda), .scl(scl), .pull(pull));
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : rnd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    task automatic dev(input logic rw, output logic ack);
        logic [7:0] r;
        m.start();
        m.xfer({4'hA, straps, rw}, 1'b1, r, ack);
    endtask : dev
    task automatic wr(input logic [11:0] a, input int n);
        logic       ack;
        logic [7:0] r;
        logic [7:0] d;
        dev(1'b0, ack);
        chk(ack, 1'b0);
        m.xfer({4'h0, a[11:8]}, 1'b1, r, ack);
        chk(ack, 1'b0);
        m.xfer(a[7:0], 1'b1, r, ack);
        chk(ack, 1'b0);
        for (int i = 0; i < n; i++) begin
            d = 8'(rnd());
            m.xfer(d, 1'b1, r, ack);
            chk(ack, 1'b0);
            if (!guard) mem[{a[11:5], 5'(a[4:0] + i)}] = d;
        end
    endtask : wr
    task automatic fin(input logic prog);
        logic ack;
        m.stop();
        repeat (40) @(negedge clk);
        chk(busy, prog);
        chk(standby, !prog);
        if (prog) begin
            dev(1'b0, ack);
            chk(ack, 1'b1);
            m.stop();
        end
        for (int i = 0; i < 4 * PROG && !standby; i++) @(negedge clk);
        chk(standby, 1'b1);
        if (!standby) summarize();
    endtask : fin
    task automatic rd(input logic [11:0] a, input int n);
        logic       ack;
        logic [7:0] r;
        wr(a, 0);
        dev(1'b1, ack);
        chk(ack, 1'b0);
        for (int i = 0; i < n; i++) begin
            m.xfer(8'hFF, i == n - 1, r, ack);
            chk(r, mem[12'(a + i)]);
        end
        m.stop();
        repeat (40) @(negedge clk);
        chk(standby, 1'b1);
    endtask : rd
    initial begin
        int         a;
        logic       ack;
        logic [7:0] r;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (20) @(negedge clk);
        chk(standby, 1'b1);
        chk(sda_oe, 1'b0);
        straps = 3'(rnd());
        wr(12'hFFE, 4);
        fin(1'b1);
        wr(12'h000, 1);
        fin(1'b1);
        rd(12'hFFE, 3);
        rd(12'hFE0, 2);
        repeat (2) begin
            a = rnd() & 32'hFF8;
            wr(12'(a), a[5:3] + 1);
            fin(1'b1);
            rd(12'(a), a[5:3] + 1);
        end
        @(negedge clk);
        guard = 1'b1;
        wr(12'hFFE, 2);
        fin(1'b0);
        rd(12'hFFE, 2);
        @(negedge clk);
        guard = 1'b0;
        for (int k = 0; k < 2; k++) begin
            m.start();
            m.xfer(k ? {4'hA, ~straps, 1'b1} : {4'h5, straps, 1'b0}, 1'b1, r, ack);
            chk(ack, 1'b1);
            m.stop();
        end
        dev(1'b0, ack);
        m.xfer(8'h00, 1'b1, r, ack);
        m.soft_reset();
        dev(1'b1, ack);
        chk(ack, 1'b0);
        m.xfer(8'hFF, 1'b1, r, ack);
        chk(r, mem[12'h000]);
        m.stop();
        repeat (40) @(negedge clk);
        summarize();
    end
endmodule : eei_tb_top
`default_nettype wire
